// ### hbnm_port.sv
`timescale 1ns/1ns
`include "hbnm_defs.svh"
module hbnm_port
   import hbnm_pkg::*;
#(
   parameter int ADDR_W = `HBNM_AW_EXT
)
(
   // clock and reset
   input  wire logic                   clk_sys_in,
   input  wire logic                   arst_n_in,
   // configuration
   input  wire hbnm_cfg_t              cfg_in,
   // user request and answer
   input  wire logic                   req_valid_in,
   input  wire hbnm_req_t              req_in,
   output logic                        req_ready_out,
   output logic                        rd_valid_out,
   output logic [15:0]                 rd_data_out,
   // bus pins
   output logic [`HBNM_PIN_W-1:0]      pin_out,
   output logic [`HBNM_PIN_W-1:0]      pin_oe_out,
   input  wire logic [15:0]            data_pin_in,
   input  wire logic                   bus_ready_in,
   output logic                        ale_out,
   output logic                        rd_strobe_out,
   output logic                        wr_strobe_out,
   output logic [3:0]                  cs_n_out,
   output logic [1:0]                  byte_lane_select_n_out
);
   typedef enum logic [1:0] {HBNM_IDLE, HBNM_LATCH, HBNM_DATA, HBNM_DONE} hbnm_state_t;

   hbnm_state_t      state_ff, nxt_state;
   hbnm_req_t        req_ff, nxt_req;
   logic             ready_ff, nxt_ready;
   logic             rdv_ff, nxt_rdv;
   logic [15:0]      rdd_ff, nxt_rdd;
   logic             ale_ff, nxt_ale, rd_ff, nxt_rd, wr_ff, nxt_wr;
   logic [3:0]       cs_n_ff, nxt_cs_n;
   logic [1:0]       bl_n_ff, nxt_bl_n;
   logic [`HBNM_PIN_W-1:0] pin_ff, nxt_pin, oe_ff, nxt_oe;
   logic             enabled, use_latch, use_byte_lane_select, use_rdy;
   logic [1:0]       cs_idx;
   logic [ADDR_W-1:0] amask;

   // mode decode; anything other than 16-bit non-muxed keeps the port idle
   assign enabled   = (cfg_in.personality == `HBNM_PERS_HB16)
                   && (cfg_in.mode == `HBNM_MODE_NONMUX);
   assign use_latch = (cfg_in.strobe_arrangement_select == `HBNM_CS_LATCH)
                   || (cfg_in.strobe_arrangement_select == `HBNM_CS_LATCH_TWO);
   assign use_byte_lane_select  = (cfg_in.byte_lane_select != `HBNM_BYTE_LANE_SELECT_NONE);
   assign use_rdy   = (cfg_in.strobe_arrangement_select != `HBNM_CS_LATCH);

   // chip select index from top address bits; reach is 12 bits for one select, 11 for two, 18 for three or four
   always_comb
   begin
      cs_idx = 2'h0;
      amask  = {ADDR_W{1'b1}};
      unique case (cfg_in.strobe_arrangement_select)
         `HBNM_CS_TWO, `HBNM_CS_LATCH_TWO:
         begin
            cs_idx = {1'b0, req_ff.addr[`HBNM_AW_BASE-1]};
            amask  = ADDR_W'((1 << (`HBNM_AW_BASE - 1)) - 1);
         end
         `HBNM_CS_THREE, `HBNM_CS_FOUR:
         begin
            cs_idx = req_ff.addr[ADDR_W-1 -: 2];
            amask  = ADDR_W'((1 << (ADDR_W - 2)) - 1);
         end
         `HBNM_CS_ONE:
            amask  = ADDR_W'((1 << `HBNM_AW_BASE) - 1);
         default:
            amask  = ADDR_W'((1 << `HBNM_AW_BASE) - 1);
      endcase
      // three selects never assert the fourth line
      if (cfg_in.strobe_arrangement_select == `HBNM_CS_THREE && cs_idx == 2'h3)
         cs_idx = 2'h2;
   end

   // bus cycle sequencer
   always_comb
   begin
      nxt_state = state_ff;
      nxt_req   = req_ff;
      nxt_ready = 1'b0;
      nxt_rdv   = 1'b0;
      nxt_rdd   = rdd_ff;
      nxt_ale   = 1'b0;
      nxt_rd    = 1'b0;
      nxt_wr    = 1'b0;
      nxt_cs_n  = 4'hf;
      nxt_bl_n  = 2'h3;
      nxt_pin   = pin_ff;
      nxt_oe    = '0;
      unique case (state_ff)
         HBNM_IDLE:
         begin
            nxt_ready = enabled;
            if (req_valid_in && ready_ff)
            begin
               nxt_req   = req_in;
               nxt_ready = 1'b0;
               nxt_state = HBNM_LATCH;
            end
         end
         HBNM_LATCH:
         begin
            // address on its own lines; data lines only driven on writes
            nxt_pin[`HBNM_DATA_LSB +: 16] = req_ff.wdata;
            nxt_pin[`HBNM_ADDR_LSB +: ADDR_W] = req_ff.addr & amask;
            nxt_oe[`HBNM_ADDR_LSB +: ADDR_W]  = {ADDR_W{1'b1}};
            nxt_oe[`HBNM_DATA_LSB +: 16] = {16{req_ff.wr}};
            nxt_ale   = use_latch;
            nxt_state = HBNM_DATA;
         end
         HBNM_DATA:
         begin
            nxt_oe    = oe_ff; // address held through the data phase
            nxt_rd    = !req_ff.wr;
            nxt_wr    = req_ff.wr;
            if (cfg_in.strobe_arrangement_select != `HBNM_CS_LATCH)
               nxt_cs_n[cs_idx] = 1'b0;
            if (use_byte_lane_select)
               nxt_bl_n = ~req_ff.lanes;
            // stretch while the peripheral holds ready low; the latch-only arrangement ignores ready
            if (!(use_rdy && rd_ff | wr_ff) || bus_ready_in)
            begin
               if (rd_ff || wr_ff)
               begin
                  nxt_rdd   = data_pin_in;
                  nxt_rdv   = !req_ff.wr;
                  nxt_rd    = 1'b0;
                  nxt_wr    = 1'b0;
                  nxt_cs_n  = 4'hf;
                  nxt_bl_n  = 2'h3;
                  nxt_state = HBNM_DONE;
               end
            end
         end
         HBNM_DONE:
         begin
            nxt_ready = enabled;
            nxt_state = HBNM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_ff <= HBNM_IDLE;
         req_ff   <= '0;
         ready_ff <= 1'b0;
         rdv_ff   <= 1'b0;
         rdd_ff   <= 16'h0000;
         ale_ff   <= 1'b0;
         rd_ff    <= 1'b0;
         wr_ff    <= 1'b0;
         cs_n_ff  <= 4'hf;
         bl_n_ff  <= 2'h3;
         pin_ff   <= '0;
         oe_ff    <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         req_ff   <= nxt_req;
         ready_ff <= nxt_ready;
         rdv_ff   <= nxt_rdv;
         rdd_ff   <= nxt_rdd;
         ale_ff   <= nxt_ale;
         rd_ff    <= nxt_rd;
         wr_ff    <= nxt_wr;
         cs_n_ff  <= nxt_cs_n;
         bl_n_ff  <= nxt_bl_n;
         pin_ff   <= nxt_pin;
         oe_ff    <= nxt_oe;
      end
   end

   assign req_ready_out          = ready_ff;
   assign rd_valid_out           = rdv_ff;
   assign rd_data_out            = rdd_ff;
   assign pin_out                = pin_ff;
   assign pin_oe_out             = oe_ff;
   assign ale_out                = ale_ff;
   assign rd_strobe_out          = rd_ff;
   assign wr_strobe_out          = wr_ff;
   assign cs_n_out               = cs_n_ff;
   assign byte_lane_select_n_out = bl_n_ff;

   // checks
   property p_onehot_cs;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (rd_ff || wr_ff) && cfg_in.strobe_arrangement_select != `HBNM_CS_LATCH |-> $onehot(~cs_n_ff);
   endproperty
   a_onehot_cs: assert property (p_onehot_cs) else $error("chip select not one-hot");
   property p_strobe_excl;
      @(posedge clk_sys_in) disable iff (!arst_n_in) !(rd_ff && wr_ff);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write together");
   property p_ale_first;
      @(posedge clk_sys_in) disable iff (!arst_n_in) ale_ff |=> (rd_ff || wr_ff) && !ale_ff;
   endproperty
   a_ale_first: assert property (p_ale_first) else $error("latch strobe not followed by data");
   property p_ale_cfg;
      @(posedge clk_sys_in) disable iff (!arst_n_in) $rose(rd_ff | wr_ff) |-> $past(ale_ff) == use_latch;
   endproperty
   a_ale_cfg: assert property (p_ale_cfg) else $error("latch strobe disagrees with arrangement");
   property p_no_byte_lane_select;
      @(posedge clk_sys_in) disable iff (!arst_n_in) !use_byte_lane_select |-> bl_n_ff == 2'h3;
   endproperty
   a_no_byte_lane_select: assert property (p_no_byte_lane_select) else $error("byte select while disabled");
   property p_stretch;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (rd_ff || wr_ff) && use_rdy && !bus_ready_in |=> (rd_ff || wr_ff);
   endproperty
   a_stretch: assert property (p_stretch) else $error("cycle ended without ready");
   property p_addr_hold;
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (rd_ff || wr_ff) |-> oe_ff[`HBNM_ADDR_LSB] && $stable(pin_ff[`HBNM_ADDR_LSB +: ADDR_W]);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in data phase");
   property p_gate;
      @(posedge clk_sys_in) disable iff (!arst_n_in) !enabled && state_ff == HBNM_IDLE |=> !ready_ff;
   endproperty
   a_gate: assert property (p_gate) else $error("ready while port not enabled");
   property p_read_done;
      @(posedge clk_sys_in) disable iff (!arst_n_in) $fell(rd_ff) |-> rdv_ff;
   endproperty
   a_read_done: assert property (p_read_done) else $error("read finished without data");
   c_read:    cover property (@(posedge clk_sys_in) rdv_ff);
   c_write:   cover property (@(posedge clk_sys_in) $fell(wr_ff));
   c_stretch: cover property (@(posedge clk_sys_in) rd_ff && !bus_ready_in ##1 rd_ff);
endmodule

// ### hbnm_defs.svh
`ifndef HBNM_DEFS_SVH
`define HBNM_DEFS_SVH
`define HBNM_PERS_HB16      2'h3
`define HBNM_MODE_NONMUX    2'h1
`define HBNM_BYTE_LANE_SELECT_NONE      2'h1
`define HBNM_CS_LATCH       3'h0
`define HBNM_CS_ONE         3'h1
`define HBNM_CS_TWO         3'h2
`define HBNM_CS_LATCH_TWO   3'h3
`define HBNM_CS_THREE       3'h4
`define HBNM_CS_FOUR        3'h5
`define HBNM_AW_BASE        12
`define HBNM_AW_EXT         20
`define HBNM_PIN_W          44
`define HBNM_DATA_LSB       0
`define HBNM_ADDR_LSB       16
`define HBNM_EXT_LINES      12
`endif

// ### hbnm_pkg.sv
package hbnm_pkg;
   typedef struct packed
   {
      logic        wr;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0]  lanes;
   } hbnm_req_t;
   typedef struct packed
   {
      logic [1:0] personality;
      logic [1:0] mode;
      logic [1:0] byte_lane_select;
      logic [2:0] strobe_arrangement_select;
   } hbnm_cfg_t;
endpackage

// ### hbnm_periph_model.sv
`timescale 1ns/1ns
// peripheral behind the port: answers reads, stretches cycles with ready
module hbnm_periph_model
(
   // clock and bus pins
   input  wire logic        clk_sys_in,
   input  wire logic [43:0] pin_in,
   input  wire logic        rd_strobe_in,
   input  wire logic        wr_strobe_in,
   // stretch control
   input  wire logic [1:0]  wait_in,
   // answer
   output logic             bus_ready_out,
   output logic [15:0]      data_out
);
   logic [1:0]  cnt_ff  = 2'h0;
   logic [15:0] junk_ff = 16'h0000;
   // strobe cycle count, saturates so a long stall cannot wrap
   always_ff @(posedge clk_sys_in)
   begin
      cnt_ff  <= !(rd_strobe_in || wr_strobe_in) ? 2'h0 : (cnt_ff == 2'h3) ? cnt_ff : cnt_ff + 2'h1;
      junk_ff <= ~junk_ff;
   end
   assign bus_ready_out = !((rd_strobe_in || wr_strobe_in) && cnt_ff < wait_in);
   // released bus toggles so a late sample cannot pass by luck
   assign data_out = rd_strobe_in ? {pin_in[23:16], ~pin_in[23:16]} : junk_ff;
endmodule

// ### test_host_bus16_nonmuxed_port.sv
`timescale 1ns/1ns
module test_host_bus16_nonmuxed_port
   import hbnm_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic arst_n_in  = 1'b0;
   hbnm_cfg_t cfg_in;
   hbnm_req_t req_in;
   logic req_valid_in, req_ready_out, rd_valid_out, bus_ready_in, ale_out, rd_strobe_out, wr_strobe_out;
   logic [15:0] rd_data_out, data_pin_in;
   logic [43:0] pin_out, pin_oe_out;
   logic [3:0]  cs_n_out;
   logic [1:0]  byte_lane_select_n_out, wait_cyc;
   int          num_errors, checked, stb_len, exp_len;
   logic [31:0] rng = 32'h9cd0;
   hbnm_req_t   exp_q[$];
   logic [15:0] rd_q[$];
   logic        ale_seen, prev_stb;
   always #5 clk_sys_in = ~clk_sys_in;
   hbnm_port i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cfg_in(cfg_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .pin_out(pin_out), .pin_oe_out(pin_oe_out), .data_pin_in(data_pin_in), .bus_ready_in(bus_ready_in),
      .ale_out(ale_out), .rd_strobe_out(rd_strobe_out), .wr_strobe_out(wr_strobe_out), .cs_n_out(cs_n_out),
      .byte_lane_select_n_out(byte_lane_select_n_out));
   hbnm_periph_model i_periph (.clk_sys_in(clk_sys_in), .pin_in(pin_out), .rd_strobe_in(rd_strobe_out),
      .wr_strobe_in(wr_strobe_out), .wait_in(wait_cyc), .bus_ready_out(bus_ready_in), .data_out(data_pin_in));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      $display("mismatches %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // holds the request until an edge that sees ready high
   task do_op(input hbnm_req_t r);
      int n;
      n = 0;
      req_in       <= r;
      req_valid_in <= 1'b1;
      exp_q.push_back(r);
      if (!r.wr)
         rd_q.push_back({r.addr[7:0], ~r.addr[7:0]});
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (req_ready_out !== 1'b1 && n < 50);
      req_valid_in <= 1'b0;
      check("taken", n < 50, 1'b1);
      // one edge with valid low, so back-to-back calls never rewrite it in one step
      @(posedge clk_sys_in);
   endtask
   // pin monitor on the falling edge, where outputs have settled
   always @(negedge clk_sys_in)
   begin
      hbnm_req_t e;
      logic [2:0] a;
      logic [3:0] ecs;
      logic [19:0] am;
      a = cfg_in.strobe_arrangement_select;
      if (ale_out === 1'b1)
         ale_seen = 1'b1;
      if ((rd_strobe_out | wr_strobe_out) === 1'b1)
      begin
         if (!prev_stb && exp_q.size() > 0)
         begin
            e = exp_q.pop_front();
            exp_len = (a == 3'h0) ? 1 : wait_cyc + 1;
            stb_len = 0;
            check("wr_strobe", wr_strobe_out, e.wr);
            check("rd_strobe", rd_strobe_out, !e.wr);
            ecs = (a == 3'h0) ? 4'hf : (a == 3'h1) ? 4'he : e.addr[11] ? 4'hd : 4'he;
            // three or four selects: top two address bits pick the line, three selects fold 3 onto 2
            if (a > 3'h3)
               ecs = ~(4'h1 << ((a == 3'h4 && e.addr[19:18] == 2'h3) ? 2'h2 : e.addr[19:18]));
            // address reach shrinks by the bits spent on chip selects
            am = (a < 3'h2) ? 20'h0_0fff : (a < 3'h4) ? 20'h0_07ff : 20'h3_ffff;
            check("cs_n", cs_n_out, ecs);
            check("lanes", byte_lane_select_n_out, (cfg_in.byte_lane_select == 2'h1) ? 2'h3 : 2'(~e.lanes));
            check("ale", ale_seen, a == 3'h0 || a == 3'h3);
            check("addr_pins", pin_out[35:16], e.addr & am);
            check("addr_oe", pin_oe_out[35:16], 20'hf_ffff);
            check("data_oe", pin_oe_out[15:0], e.wr ? 16'hffff : 16'h0000);
            if (e.wr)
               check("wr_data", pin_out[15:0], e.wdata);
            ale_seen = 1'b0;
         end
         stb_len++;
      end
      else if (prev_stb)
         check("strobe_len", 20'(stb_len), 20'(exp_len));
      prev_stb = rd_strobe_out | wr_strobe_out;
      if (rd_valid_out === 1'b1)
         check("rd_data", rd_data_out, rd_q.pop_front());
   end
   // watchdog sized well above the 48 operations of the run
   initial
   begin
      #500000;
      num_errors++;
      wrap_up;
   end
   initial
   begin
      hbnm_req_t r;
      cfg_in = '{personality: 2'h3, mode: 2'h1, byte_lane_select: 2'h0, strobe_arrangement_select: 3'h0};
      req_valid_in = 1'b0;
      req_in = '0;
      wait_cyc = 2'h0;
      num_errors = 0;
      checked = 0;
      ale_seen = 1'b0;
      prev_stb = 1'b0;
      repeat (10) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      // every arrangement with and without byte lanes, back-to-back ops
      for (int a = 0; a < 6; a++)
         for (int b = 0; b < 2; b++)
         begin
            cfg_in.strobe_arrangement_select <= a[2:0];
            cfg_in.byte_lane_select <= b[1:0];
            repeat (3) @(posedge clk_sys_in);
            for (int k = 0; k < 4; k++)
            begin
               rng = xs(rng);
               r = '{wr: rng[0], addr: rng[31:12], wdata: rng[15:0], lanes: (rng[2:1] == 2'h0) ? 2'h3 : rng[2:1]};
               do_op(r);
               wait_cyc <= rng[4:3];
            end
            repeat (12) @(posedge clk_sys_in);
         end
      // wrong mode, then wrong personality: requests refused
      cfg_in.mode <= 2'h0;
      repeat (3) @(posedge clk_sys_in);
      check("ready_mode", req_ready_out, 1'b0);
      cfg_in <= '{personality: 2'h0, mode: 2'h1, byte_lane_select: 2'h0, strobe_arrangement_select: 3'h1};
      repeat (3) @(posedge clk_sys_in);
      check("ready_pers", req_ready_out, 1'b0);
      wrap_up;
   end
endmodule
